// >>> rtl/mcc_pkg.sv
// package of offsets, field positions, reset values and timing counts for the clock controller
package mcc_pkg;

    // ------------------------------------------------------------
    // register indices and byte addresses (byte address = 4 * index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_CLOCK_CONTROL_STATUS = 8'h2C;
    localparam logic [7:0] IDX_BEEP_CONTROL = 8'h2D;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h30;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h31;
    localparam logic [9:0] ADDR_CLOCK_CONTROL_STATUS = {IDX_CLOCK_CONTROL_STATUS, 2'b00};
    localparam logic [9:0] ADDR_BEEP_CONTROL = {IDX_BEEP_CONTROL, 2'b00};
    localparam logic [9:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
    localparam logic [9:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};
    localparam int ADDR_WIDTH = 10;

    // ------------------------------------------------------------
    // clock_control_status fields
    // ------------------------------------------------------------
    localparam int POS_CLOCK_OUT_ENABLE = 7;
    localparam int POS_SLOW_CLOCK_DIVIDER = 5;
    localparam int POS_SLOW_MODE_SELECT = 4;
    localparam int POS_TIME_BASE_SELECT = 2;
    localparam int POS_TIME_BASE_IRQ_ENABLE = 1;
    localparam int POS_TIME_BASE_FLAG = 0;
    localparam logic [7:0] RESET_CLOCK_CONTROL_STATUS = 8'h00;

    // ------------------------------------------------------------
    // beep_control fields
    // ------------------------------------------------------------
    localparam int POS_BEEP_TONE_SELECT = 0;
    localparam logic [7:0] RESET_BEEP_CONTROL = 8'h00;

    // ------------------------------------------------------------
    // interrupt status / mask fields
    // ------------------------------------------------------------
    localparam int POS_IRQ_TIME_BASE = 0;
    localparam int POS_IRQ_WAKE = 1;
    localparam int IRQ_BITS = 2;
    localparam logic [1:0] RESET_IRQ_STATUS = 2'h0;
    localparam logic [1:0] RESET_IRQ_MASK = 2'h0;

    // ------------------------------------------------------------
    // time-base periods in oscillator cycles
    // ------------------------------------------------------------
    localparam int TB_PERIOD_00 = 16000;
    localparam int TB_PERIOD_01 = 32000;
    localparam int TB_PERIOD_10 = 80000;
    localparam int TB_PERIOD_11 = 200000;
    localparam int TB_COUNT_WIDTH = 18;

    // ------------------------------------------------------------
    // beep tones, frequencies given for the reference oscillator rate
    // ------------------------------------------------------------
    localparam int BEEP_OSC_HZ = 8000000;
    localparam int BEEP_TONE_01_HZ = 2000;
    localparam int BEEP_TONE_10_HZ = 1000;
    localparam int BEEP_TONE_11_HZ = 500;
    localparam int BEEP_HALF_01 = BEEP_OSC_HZ / (2 * BEEP_TONE_01_HZ);
    localparam int BEEP_HALF_10 = BEEP_OSC_HZ / (2 * BEEP_TONE_10_HZ);
    localparam int BEEP_HALF_11 = BEEP_OSC_HZ / (2 * BEEP_TONE_11_HZ);
    localparam int BEEP_COUNT_WIDTH = 14;

    // slow-mode prescaler width, divide by up to 16
    localparam int PRESCALE_WIDTH = 4;

    typedef enum logic [1:0] {
        PM_RUN,
        PM_WAIT,
        PM_ACTIVE_HALT,
        PM_HALT
    } power_mode_e;

endpackage

// >>> rtl/main_clock_rtc_beeper.sv
// main clock controller: cpu prescaler, clock-out, time base counter and beeper
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps

module main_clock_rtc_beeper #(
    parameter int TB_PERIOD_00 = mcc_pkg::TB_PERIOD_00,
    parameter int TB_PERIOD_01 = mcc_pkg::TB_PERIOD_01,
    parameter int TB_PERIOD_10 = mcc_pkg::TB_PERIOD_10,
    parameter int TB_PERIOD_11 = mcc_pkg::TB_PERIOD_11,
    parameter int BEEP_HALF_01 = mcc_pkg::BEEP_HALF_01,
    parameter int BEEP_HALF_10 = mcc_pkg::BEEP_HALF_10,
    parameter int BEEP_HALF_11 = mcc_pkg::BEEP_HALF_11
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [mcc_pkg::ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // cpu core and power logic
    input wire logic wait_instruction,
    input wire logic halt_instruction,
    input wire logic other_irq_pending,
    input wire logic halt_exit_irq,
    output logic time_base_irq_request,
    output logic cpu_clock_tick,
    output logic wait_mode,
    output logic active_halt_mode,
    output logic halt_mode,
    output logic wake_pulse,
    // pins
    output logic clock_out_pin_out,
    output logic clock_out_pin_oe,
    output logic beep_pin_out,
    output logic beep_pin_oe,
    // interrupt
    output logic irq
);

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic clock_out_enable;
    logic [1:0] slow_clock_divider;
    logic slow_mode_select;
    logic [1:0] time_base_select;
    logic time_base_irq_enable;
    logic time_base_flag;
    logic [1:0] beep_tone_select;
    logic [mcc_pkg::IRQ_BITS-1:0] irq_status;
    logic [mcc_pkg::IRQ_BITS-1:0] irq_mask;

    logic [1:0] active_tb_select;
    logic [mcc_pkg::TB_COUNT_WIDTH-1:0] tb_count;
    logic [mcc_pkg::PRESCALE_WIDTH-1:0] prescale_count;
    logic [mcc_pkg::BEEP_COUNT_WIDTH-1:0] beep_count;
    logic read_saw_flag;

    mcc_pkg::power_mode_e power_mode;
    mcc_pkg::power_mode_e next_power_mode;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // last count value of the period chosen by a select code
    function automatic logic [mcc_pkg::TB_COUNT_WIDTH-1:0] tb_last(input logic [1:0] sel);
        int period;
        unique case (sel)
            2'b00: period = TB_PERIOD_00;
            2'b01: period = TB_PERIOD_01;
            2'b10: period = TB_PERIOD_10;
            2'b11: period = TB_PERIOD_11;
        endcase
        return mcc_pkg::TB_COUNT_WIDTH'(period - 1);
    endfunction

    // last count of a beep half period
    function automatic logic [mcc_pkg::BEEP_COUNT_WIDTH-1:0] beep_last(input logic [1:0] sel);
        int half;
        unique case (sel)
            2'b01: half = BEEP_HALF_01;
            2'b10: half = BEEP_HALF_10;
            2'b11: half = BEEP_HALF_11;
            2'b00: half = 1;
        endcase
        return mcc_pkg::BEEP_COUNT_WIDTH'(half - 1);
    endfunction

    // register decode shared by read and write paths
    function automatic logic addr_hit(input logic [mcc_pkg::ADDR_WIDTH-1:0] a);
        return (a == mcc_pkg::ADDR_CLOCK_CONTROL_STATUS) || (a == mcc_pkg::ADDR_BEEP_CONTROL)
            || (a == mcc_pkg::ADDR_IRQ_STATUS) || (a == mcc_pkg::ADDR_IRQ_MASK);
    endfunction

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic setup_phase;
    logic access_done;
    logic write_done;
    logic read_done;
    logic regs_frozen;
    logic counter_frozen;
    logic period_end;
    logic tb_request;

    assign setup_phase = psel && !penable;
    assign access_done = psel && penable && pready;
    // cpu is stopped in both halt modes, so register writes are held off
    assign regs_frozen = (power_mode == mcc_pkg::PM_ACTIVE_HALT)
        || (power_mode == mcc_pkg::PM_HALT);
    assign write_done = access_done && pwrite && !pslverr && !regs_frozen && pstrb[0];
    assign read_done = access_done && !pwrite && !pslverr;
    assign counter_frozen = (power_mode == mcc_pkg::PM_HALT);
    assign period_end = !counter_frozen && (tb_count == tb_last(active_tb_select));
    assign tb_request = time_base_flag && time_base_irq_enable;

    // ------------------------------------------------------------
    // apb answer: one access cycle, data captured at setup
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            read_saw_flag <= 1'b0;
        end else begin
            pready <= setup_phase;
            if (setup_phase) begin
                pslverr <= !addr_hit(paddr);
                read_saw_flag <= 1'b0;
                prdata <= 32'h00000000;
                if (paddr == mcc_pkg::ADDR_CLOCK_CONTROL_STATUS) begin
                    prdata[7:0] <= {clock_out_enable, slow_clock_divider, slow_mode_select,
                        time_base_select, time_base_irq_enable, time_base_flag};
                    read_saw_flag <= time_base_flag;
                end else if (paddr == mcc_pkg::ADDR_BEEP_CONTROL) begin
                    prdata[1:0] <= beep_tone_select;
                end else if (paddr == mcc_pkg::ADDR_IRQ_STATUS) begin
                    prdata[mcc_pkg::IRQ_BITS-1:0] <= irq_status;
                end else if (paddr == mcc_pkg::ADDR_IRQ_MASK) begin
                    prdata[mcc_pkg::IRQ_BITS-1:0] <= irq_mask;
                end
            end else if (access_done) begin
                pslverr <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // control fields written by software
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            clock_out_enable <= mcc_pkg::RESET_CLOCK_CONTROL_STATUS[mcc_pkg::POS_CLOCK_OUT_ENABLE];
            slow_clock_divider <=
                mcc_pkg::RESET_CLOCK_CONTROL_STATUS[mcc_pkg::POS_SLOW_CLOCK_DIVIDER +: 2];
            slow_mode_select <= mcc_pkg::RESET_CLOCK_CONTROL_STATUS[mcc_pkg::POS_SLOW_MODE_SELECT];
            time_base_select <=
                mcc_pkg::RESET_CLOCK_CONTROL_STATUS[mcc_pkg::POS_TIME_BASE_SELECT +: 2];
            time_base_irq_enable <=
                mcc_pkg::RESET_CLOCK_CONTROL_STATUS[mcc_pkg::POS_TIME_BASE_IRQ_ENABLE];
            beep_tone_select <= mcc_pkg::RESET_BEEP_CONTROL[mcc_pkg::POS_BEEP_TONE_SELECT +: 2];
            irq_mask <= mcc_pkg::RESET_IRQ_MASK;
        end else if (write_done) begin
            if (paddr == mcc_pkg::ADDR_CLOCK_CONTROL_STATUS) begin
                clock_out_enable <= pwdata[mcc_pkg::POS_CLOCK_OUT_ENABLE];
                slow_clock_divider <= pwdata[mcc_pkg::POS_SLOW_CLOCK_DIVIDER +: 2];
                slow_mode_select <= pwdata[mcc_pkg::POS_SLOW_MODE_SELECT];
                time_base_select <= pwdata[mcc_pkg::POS_TIME_BASE_SELECT +: 2];
                time_base_irq_enable <= pwdata[mcc_pkg::POS_TIME_BASE_IRQ_ENABLE];
            end else if (paddr == mcc_pkg::ADDR_BEEP_CONTROL) begin
                // upper bits are not stored, software keeps them zero
                beep_tone_select <= pwdata[mcc_pkg::POS_BEEP_TONE_SELECT +: 2];
            end else if (paddr == mcc_pkg::ADDR_IRQ_MASK) begin
                irq_mask <= pwdata[mcc_pkg::IRQ_BITS-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // time base counter
    // ------------------------------------------------------------
    // the selection in use is only reloaded at a period boundary, so a
    // rewrite mid-period never stretches or cuts the real-time count
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            tb_count <= '0;
            active_tb_select <=
                mcc_pkg::RESET_CLOCK_CONTROL_STATUS[mcc_pkg::POS_TIME_BASE_SELECT +: 2];
        end else if (period_end) begin
            tb_count <= '0;
            active_tb_select <= time_base_select;
        end else if (!counter_frozen) begin
            tb_count <= tb_count + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // time base flag: set at period end, cleared by reading the register
    // ------------------------------------------------------------
    // only a flag value actually returned to software is cleared, and a new
    // period end in the same cycle wins over the clear
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            time_base_flag <= mcc_pkg::RESET_CLOCK_CONTROL_STATUS[mcc_pkg::POS_TIME_BASE_FLAG];
        end else if (period_end) begin
            time_base_flag <= 1'b1;
        end else if (read_done && paddr == mcc_pkg::ADDR_CLOCK_CONTROL_STATUS
            && read_saw_flag) begin
            time_base_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // power modes
    // ------------------------------------------------------------
    always_comb begin
        next_power_mode = power_mode;
        unique case (power_mode)
            mcc_pkg::PM_RUN: begin
                if (halt_instruction) begin
                    // enable bit chooses active halt
                    next_power_mode = time_base_irq_enable ? mcc_pkg::PM_ACTIVE_HALT
                        : mcc_pkg::PM_HALT;
                end else if (wait_instruction) begin
                    next_power_mode = mcc_pkg::PM_WAIT;
                end
            end
            mcc_pkg::PM_WAIT: begin
                if (tb_request || other_irq_pending || halt_exit_irq) begin
                    next_power_mode = mcc_pkg::PM_RUN;
                end
            end
            mcc_pkg::PM_ACTIVE_HALT: begin
                if (tb_request || halt_exit_irq) begin
                    next_power_mode = mcc_pkg::PM_RUN;
                end
            end
            mcc_pkg::PM_HALT: begin
                // the time base cannot wake this mode, only a halt-exit source
                if (halt_exit_irq) begin
                    next_power_mode = mcc_pkg::PM_RUN;
                end
            end
        endcase
    end

    // mode state plus registered mode indications
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            power_mode <= mcc_pkg::PM_RUN;
            wait_mode <= 1'b0;
            active_halt_mode <= 1'b0;
            halt_mode <= 1'b0;
            wake_pulse <= 1'b0;
        end else begin
            power_mode <= next_power_mode;
            wait_mode <= (next_power_mode == mcc_pkg::PM_WAIT);
            active_halt_mode <= (next_power_mode == mcc_pkg::PM_ACTIVE_HALT);
            halt_mode <= (next_power_mode == mcc_pkg::PM_HALT);
            wake_pulse <= (power_mode != mcc_pkg::PM_RUN) && (next_power_mode == mcc_pkg::PM_RUN);
        end
    end

    // ------------------------------------------------------------
    // cpu clock prescaler and clock-out pin
    // ------------------------------------------------------------
    // the cpu clock is carried as a tick per cpu cycle; the pin shows a square
    // wave, which in normal mode can only reach half the oscillator rate
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            prescale_count <= '0;
            cpu_clock_tick <= 1'b0;
            clock_out_pin_out <= 1'b0;
            clock_out_pin_oe <= 1'b0;
        end else begin
            prescale_count <= prescale_count + 1'b1;
            if (regs_frozen) begin
                cpu_clock_tick <= 1'b0;
                clock_out_pin_out <= 1'b0;
                clock_out_pin_oe <= clock_out_enable;
            end else if (slow_mode_select) begin
                // divide by 2 << code
                cpu_clock_tick <= (prescale_count & ((4'h2 << slow_clock_divider) - 4'h1))
                    == 4'h0;
                clock_out_pin_out <= prescale_count[slow_clock_divider] && clock_out_enable;
                clock_out_pin_oe <= clock_out_enable;
            end else begin
                cpu_clock_tick <= 1'b1;
                clock_out_pin_out <= !clock_out_pin_out && clock_out_enable;
                clock_out_pin_oe <= clock_out_enable;
            end
        end
    end

    // ------------------------------------------------------------
    // beeper
    // ------------------------------------------------------------
    // keeps toggling in active halt, stops with the oscillator in full halt
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            beep_count <= '0;
            beep_pin_out <= 1'b0;
            beep_pin_oe <= 1'b0;
        end else if (beep_tone_select == 2'b00) begin
            beep_count <= '0;
            beep_pin_out <= 1'b0;
            beep_pin_oe <= 1'b0;
        end else if (!counter_frozen) begin
            beep_pin_oe <= 1'b1;
            if (beep_count >= beep_last(beep_tone_select)) begin
                beep_count <= '0;
                beep_pin_out <= !beep_pin_out;
            end else begin
                beep_count <= beep_count + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt request, sticky status and mask
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            irq_status <= mcc_pkg::RESET_IRQ_STATUS;
            time_base_irq_request <= 1'b0;
            irq <= 1'b0;
        end else begin
            for (int i = 0; i < mcc_pkg::IRQ_BITS; i++) begin
                if (write_done && paddr == mcc_pkg::ADDR_IRQ_STATUS && pwdata[i]) begin
                    irq_status[i] <= 1'b0;
                end
            end
            // set after clear so an event in the clearing cycle survives
            if (period_end) begin
                irq_status[mcc_pkg::POS_IRQ_TIME_BASE] <= 1'b1;
            end
            if (power_mode != mcc_pkg::PM_RUN && next_power_mode == mcc_pkg::PM_RUN) begin
                irq_status[mcc_pkg::POS_IRQ_WAKE] <= 1'b1;
            end
            // the pin shows the request a cycle late; wake logic uses the early form
            time_base_irq_request <= tb_request;
            irq <= |(irq_status & irq_mask);
        end
    end

endmodule

// >>> verification/mcc_checker.sv
// checker of power-mode, wake and pin behaviour of the clock controller
`timescale 1ns/1ps
module mcc_checker (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic wait_instruction,
    input wire logic halt_instruction,
    input wire logic halt_exit_irq,
    input wire logic time_base_irq_request,
    input wire logic wait_mode,
    input wire logic active_halt_mode,
    input wire logic halt_mode,
    input wire logic wake_pulse,
    input wire logic clock_out_pin_out,
    input wire logic beep_pin_out,
    input wire logic beep_pin_oe
);
    // ----------------------------------------
    // mode relations
    // ----------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    logic low;
    logic asleep;
    // any low-power mode, and the two halt flavours where clocks stop
    assign low = wait_mode | active_halt_mode | halt_mode;
    assign asleep = active_halt_mode | halt_mode;
    property p_enter_halt; halt_instruction && !low |=> asleep; endproperty
    a_enter_halt: assert property (p_enter_halt) else $error("halt entry missed");
    property p_enter_wait; wait_instruction && !low |=> wait_mode; endproperty
    a_enter_wait: assert property (p_enter_wait) else $error("wait entry missed");
    property p_wait_exit; wait_mode && time_base_irq_request |=> !wait_mode; endproperty
    a_wait_exit: assert property (p_wait_exit) else $error("wait not left");
    property p_ah_exit;
        active_halt_mode && time_base_irq_request |=> !active_halt_mode;
    endproperty
    a_ah_exit: assert property (p_ah_exit) else $error("active halt not left");
    property p_halt_holds; halt_mode && !halt_exit_irq |=> halt_mode; endproperty
    a_halt_holds: assert property (p_halt_holds) else $error("halt left early");
    property p_clkout_off; asleep && $past(asleep) |-> !clock_out_pin_out; endproperty
    a_clkout_off: assert property (p_clkout_off) else $error("clock-out runs asleep");
    property p_beep_frozen;
        halt_mode && $past(halt_mode) |-> $stable(beep_pin_out) && $stable(beep_pin_oe);
    endproperty
    a_beep_frozen: assert property (p_beep_frozen) else $error("beep moves in halt");
    property p_wake; $fell(low) |-> ##[0:1] wake_pulse; endproperty
    a_wake: assert property (p_wake) else $error("no wake pulse");
    c_wait_wake: cover property (wait_mode && time_base_irq_request);
    c_ah_wake: cover property (active_halt_mode && time_base_irq_request);
    c_halt_wake: cover property ($fell(halt_mode));
endmodule

bind main_clock_rtc_beeper mcc_checker chk_i (.*);

// >>> verification/cpu_power_model.sv
// behavioural model of the cpu core and power logic facing the clock controller
`timescale 1ns/1ps
module cpu_power_model (
    input wire logic ref_clk,
    output logic wait_instruction,
    output logic halt_instruction,
    output logic other_irq_pending,
    output logic halt_exit_irq
);
    // ----------------------------------------
    // core side
    // ----------------------------------------
    initial begin
        wait_instruction = 1'b0;
        halt_instruction = 1'b0;
        other_irq_pending = 1'b0;
        halt_exit_irq = 1'b0;
    end
    // one-cycle instruction pulse; which halt results is the block's choice
    task automatic instr(input logic h);
        wait_instruction <= !h;
        halt_instruction <= h;
        @(posedge ref_clk);
        wait_instruction <= 1'b0;
        halt_instruction <= 1'b0;
    endtask
    // halt-capable interrupt held a few cycles, the only way out of full halt
    task automatic exit_irq();
        halt_exit_irq <= 1'b1;
        repeat (3) @(posedge ref_clk);
        halt_exit_irq <= 1'b0;
    endtask
    // any other source: ends wait, but neither halt flavour
    task automatic other_irq();
        other_irq_pending <= 1'b1;
        @(posedge ref_clk);
        other_irq_pending <= 1'b0;
    endtask
endmodule

// >>> verification/main_clock_rtc_beeper_tb_top.sv
// self-checking bench of the clock controller
`timescale 1ns/1ps
module main_clock_rtc_beeper_tb_top;
    logic ref_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e, p;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, wait_instruction, halt_instruction, other_irq_pending, halt_exit_irq;
    logic time_base_irq_request, cpu_clock_tick, wait_mode, active_halt_mode, halt_mode;
    logic wake_pulse, clock_out_pin_out, clock_out_pin_oe, beep_pin_out, beep_pin_oe, irq;
    int error_cnt = 0, comparisons = 0, cyc = 0, t0, t1, n, old;
    localparam int P[4] = '{16, 32, 80, 200};
    localparam int H[4] = '{0, 4, mcc_pkg::BEEP_HALF_10, mcc_pkg::BEEP_HALF_11};
    localparam logic [9:0] CS = mcc_pkg::ADDR_CLOCK_CONTROL_STATUS;
    localparam logic [9:0] BC = mcc_pkg::ADDR_BEEP_CONTROL;
    localparam logic [9:0] IS = mcc_pkg::ADDR_IRQ_STATUS;
    localparam logic [9:0] IM = mcc_pkg::ADDR_IRQ_MASK;
    // ----------------------------------------
    // clock, design and core model
    // ----------------------------------------
    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;
    // short time bases; the two low tones keep their real half periods
    main_clock_rtc_beeper #(.TB_PERIOD_00(16), .TB_PERIOD_01(32), .TB_PERIOD_10(80),
        .TB_PERIOD_11(200), .BEEP_HALF_01(4)) uut (.*);
    cpu_power_model cpu (.*);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // apb transfer held until pready is sampled, then an idle cycle
    task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin @(posedge ref_clk); k++; end while (pready !== 1'b1 && k < 50);
        q = prdata; e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] x);
        apb(1'b0, a, 0);
        chk(q, x);
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
    // clears the flag, then times the next rise of the request
    task automatic tick(output int t);
        int k;
        k = 0;
        apb(1'b0, CS, 0);
        while (time_base_irq_request !== 1'b0 && k < 999) begin @(posedge ref_clk); k++; end
        while (time_base_irq_request !== 1'b1 && k < 999) begin @(posedge ref_clk); k++; end
        t = cyc;
    endtask
    task automatic to_run();
        int k;
        k = 0;
        while ({wait_mode, active_halt_mode, halt_mode} !== 3'b000 && k < 400) begin
            @(posedge ref_clk); k++;
        end
        chk({wait_mode, active_halt_mode, halt_mode}, 0);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        rd(CS, 0); rd(BC, 0); rd(IS, 0); rd(IM, 0);
        apb(1'b0, 10'h3FC, 0); chk(e, 1);
        pstrb <= 4'h0; wr(BC, 3); rd(BC, 0); pstrb <= 4'hF;
    endtask
    task automatic t_period();
        wr(CS, 32'h02); old = 0; tick(t0);
        for (int s = 0; s < 4; s++) begin
            rd(CS, old * 4 + 3);
            rd(CS, old * 4 + 2);
            wr(CS, s * 4 + 2);
            tick(t1); chk(t1 - t0, P[old]);
            tick(t0); chk(t0 - t1, P[s]);
            old = s;
        end
    endtask
    task automatic t_irq();
        wr(IM, 1); wr(IS, 3); @(posedge ref_clk); chk(irq, 0); rd(IS, 0);
        tick(t0); repeat (2) @(posedge ref_clk); chk(irq, 1);
        wr(IM, 0); tick(t0); repeat (2) @(posedge ref_clk); chk(irq, 0); rd(IS, 1); wr(IS, 1);
    endtask
    task automatic t_pins();
        for (int c = 0; c < 5; c++) begin
            wr(CS, c < 4 ? 32'h90 + c * 32 : 0); n = 0;
            repeat (32) begin @(posedge ref_clk); n += cpu_clock_tick; end
            chk(n, c < 4 ? 32 >> (c + 1) : 32);
            chk(clock_out_pin_oe, c < 4);
        end
        for (int t = 1; t < 4; t++) begin
            wr(BC, t); n = 0; p = beep_pin_out;
            while (beep_pin_out === p && n < 9999) begin @(posedge ref_clk); n++; end
            p = beep_pin_out; n = 0;
            while (beep_pin_out === p && n < 9999) begin @(posedge ref_clk); n++; end
            chk(n, H[t]); chk(beep_pin_oe, 1);
        end
        wr(BC, 0); @(posedge ref_clk); chk(beep_pin_oe, 0);
    endtask
    task automatic t_power();
        wr(CS, 32'h86); wr(BC, 1); apb(1'b0, CS, 0);
        cpu.instr(1'b0); @(posedge ref_clk); chk(wait_mode, 1); to_run();
        apb(1'b0, CS, 0); cpu.instr(1'b1); @(posedge ref_clk); chk(active_halt_mode, 1);
        n = 0; p = beep_pin_out;
        repeat (8) begin @(posedge ref_clk); n += (beep_pin_out !== p); p = beep_pin_out; end
        chk(n >= 2, 1); wr(BC, 0); cpu.other_irq(); @(posedge ref_clk);
        chk(active_halt_mode, 1); to_run(); rd(BC, 1);
        wr(CS, 32'h80); cpu.instr(1'b1); @(posedge ref_clk); chk(halt_mode, 1);
        repeat (80) @(posedge ref_clk); chk(halt_mode, 1);
        cpu.exit_irq(); to_run();
    endtask
    task automatic give_verdict();
        if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        t_regs(); t_period(); t_irq(); t_pins(); t_power();
        give_verdict();
    end
    // hang guard, well above the roughly 26000 cycles needed
    initial begin
        repeat (40000) @(posedge ref_clk);
        error_cnt++;
        give_verdict();
    end
endmodule
